// ---- hdl/cfd_map.svh ----
// Purpose: offsets, field positions and reset values for the config field decoder
// Assumes: a flat configuration word presented on a single input bus
// Notes: positions are local packing of the raw configuration word
`ifndef CFD_MAP_SVH
`define CFD_MAP_SVH

// =====================================================================
// raw word layout
`define CFD_RAW_W 17
`define CFD_WIN_LSB 0
`define CFD_I2C1_BIT 2
`define CFD_I2C2_BIT 3
`define CFD_TEST_BIT 4
`define CFD_DBG_LSB 5
`define CFD_DAC_BIT 7
`define CFD_SET1_LSB 8
`define CFD_SET2_LSB 11
`define CFD_SET3_LSB 14

// =====================================================================
// window fractions in eighths of the period
`define CFD_WIN_25 4'h2
`define CFD_WIN_37 4'h3
`define CFD_WIN_50 4'h4
`define CFD_WIN_75 4'h6

// =====================================================================
// reset values of decoded outputs
`define CFD_RST_WIN 4'h6
`define CFD_RST_LEVEL 3'h1

`endif

// ---- hdl/cfd_pkg.sv ----
// Purpose: types for the config field decoder
// Assumes: constants live in cfd_map.svh
// Notes: none
package cfd_pkg;

	// =====================================================================
	// debug channel routing, one-hot
	typedef enum logic [3:0]
	{
		CFD_DBG_NONE = 4'h1,
		CFD_DBG_ONE = 4'h2,
		CFD_DBG_TWO = 4'h4,
		CFD_DBG_THREE = 4'h8
	} cfd_dbg_t;

	// =====================================================================
	// loader sequencing, one-hot
	typedef enum logic [1:0]
	{
		CFD_ST_LOAD = 2'h1,
		CFD_ST_HOLD = 2'h2
	} cfd_state_t;

endpackage : cfd_pkg

// ---- hdl/cfd_level_dec.sv ----
// Purpose: decodes a three-bit shadow set priority field
// Assumes: combinational, used per shadow set
// Notes: code 7 is reserved and flagged
`timescale 1ns/10ps
module cfd_level_dec
(
	// field in
	input wire logic [2:0] code_i,
	// decoded
	output logic [2:0] level_o,
	output logic reserved_o
);

	// =====================================================================
	// codes 0..6 map to levels 1..7
	always_comb
	begin
		reserved_o = (code_i == 3'h7);
		level_o = reserved_o ? 3'h0 : 3'(code_i + 3'h1);
	end

endmodule : cfd_level_dec

// ---- hdl/cfd_config_decode.sv ----
// Contract
// [RQ1] window select sets open fraction of period
// [RQ2] first i2c: 1 primary pins, 0 alternate
// [RQ3] second i2c: 1 primary pins, 0 alternate
// [RQ4] test port works only while enable is 1
// [RQ5] debug select 11/10/01 picks pair 1/2/3
// [RQ6] programmer never writes debug select 00
// [RQ7] dac cross bit 0 ties outputs together
// [RQ8] set one priority 000..110 gives levels 1..7
// [RQ9] set two priority decodes the same way
// [RQ10] set three priority decodes the same way
// [RQ11] alternate vector table needs boot segment
// [RQ12] outputs latched after reset, held until next; ALT_VECTOR_ON_O follows its request while loaded instead
//
// Purpose: decodes nonvolatile configuration fields into static controls
// Assumes: raw word is stable from a slow domain; sampled through two flops
// Notes: one load after reset release, then frozen except the alternate vector enable, which follows its request
`timescale 1ns/10ps
`include "cfd_map.svh"
module cfd_config_decode
(
	// clock and reset
	input wire logic CORE_CLK_I,
	input wire logic NRST_I,
	// configuration inputs
	input wire logic [`CFD_RAW_W-1:0] CFG_WORD_I,
	input wire logic BOOT_SEG_PRESENT_I,
	input wire logic ALT_VECTOR_REQ_I,
	// decoded controls
	output logic [3:0] WIN_EIGHTHS_O,
	output logic I2C1_PRIMARY_O,
	output logic I2C2_PRIMARY_O,
	output logic TEST_PORT_ON_O,
	output logic [3:0] DEBUG_PAIR_O,
	output logic DEBUG_RESERVED_O,
	output logic DAC_TIED_O,
	output logic [2:0] SET1_LEVEL_O,
	output logic [2:0] SET2_LEVEL_O,
	output logic [2:0] SET3_LEVEL_O,
	output logic LEVEL_RESERVED_O,
	output logic ALT_VECTOR_ON_O,
	output logic LOADED_O
);

	// =====================================================================
	// state
	typedef struct packed
	{
		logic [`CFD_RAW_W-1:0] sync1;
		logic [`CFD_RAW_W-1:0] sync2;
		logic [1:0] boot_sync1;
		logic [1:0] boot_sync2;
		logic [1:0] settle;
		cfd_pkg::cfd_state_t state;
		logic [3:0] win;
		logic i2c1;
		logic i2c2;
		logic test_on;
		cfd_pkg::cfd_dbg_t dbg;
		logic dbg_rsv;
		logic dac_tied;
		logic [2:0] lv1;
		logic [2:0] lv2;
		logic [2:0] lv3;
		logic lv_rsv;
		logic boot_seg;
		logic alt_vec;
		logic loaded;
	} cfd_regs_t;

	cfd_regs_t r;
	cfd_regs_t next_r;

	logic [2:0] dl1;
	logic [2:0] dl2;
	logic [2:0] dl3;
	logic rs1;
	logic rs2;
	logic rs3;

	// =====================================================================
	// window code to eighths of period
	function automatic logic [3:0] win_fraction(input logic [1:0] code);
		case (code)
			2'h3: win_fraction = `CFD_WIN_25;
			2'h2: win_fraction = `CFD_WIN_37;
			2'h1: win_fraction = `CFD_WIN_50;
			default: win_fraction = `CFD_WIN_75;
		endcase
	endfunction : win_fraction

	// =====================================================================
	// priority field decoders, one per shadow set
	cfd_level_dec u_dec1
	(
		.code_i(r.sync2[`CFD_SET1_LSB +: 3]),
		.level_o(dl1),
		.reserved_o(rs1)
	);
	cfd_level_dec u_dec2
	(
		.code_i(r.sync2[`CFD_SET2_LSB +: 3]),
		.level_o(dl2),
		.reserved_o(rs2)
	);
	cfd_level_dec u_dec3
	(
		.code_i(r.sync2[`CFD_SET3_LSB +: 3]),
		.level_o(dl3),
		.reserved_o(rs3)
	);

	// =====================================================================
	// next state
	always_comb
	begin
		next_r = r;
		next_r.sync1 = CFG_WORD_I;
		next_r.sync2 = r.sync1;
		next_r.boot_sync1 = {ALT_VECTOR_REQ_I, BOOT_SEG_PRESENT_I};
		next_r.boot_sync2 = r.boot_sync1;
		case (r.state)
			cfd_pkg::CFD_ST_LOAD:
			begin
				// wait until synchroniser holds settled data
				next_r.settle = 2'(r.settle + 2'h1);
				if (r.settle == 2'h3)
				begin
					next_r.state = cfd_pkg::CFD_ST_HOLD;
					next_r.loaded = 1'b1; // [RQ12]
					next_r.win = win_fraction(r.sync2[`CFD_WIN_LSB +: 2]); // [RQ1]
					next_r.i2c1 = r.sync2[`CFD_I2C1_BIT]; // [RQ2]
					next_r.i2c2 = r.sync2[`CFD_I2C2_BIT]; // [RQ3]
					next_r.test_on = r.sync2[`CFD_TEST_BIT]; // [RQ4]
					next_r.dac_tied = ~r.sync2[`CFD_DAC_BIT]; // [RQ7]
					next_r.lv1 = dl1; // [RQ8]
					next_r.lv2 = dl2; // [RQ9]
					next_r.lv3 = dl3; // [RQ10]
					next_r.lv_rsv = rs1 | rs2 | rs3;
					next_r.boot_seg = r.boot_sync2[0];
					next_r.dbg_rsv = 1'b0;
					// [RQ5] reserved code 00 leaves debug unrouted [RQ6]
					case (r.sync2[`CFD_DBG_LSB +: 2])
						2'h3: next_r.dbg = cfd_pkg::CFD_DBG_ONE;
						2'h2: next_r.dbg = cfd_pkg::CFD_DBG_TWO;
						2'h1: next_r.dbg = cfd_pkg::CFD_DBG_THREE;
						default:
						begin
							next_r.dbg = cfd_pkg::CFD_DBG_NONE;
							next_r.dbg_rsv = 1'b1;
						end
					endcase
				end
			end
			cfd_pkg::CFD_ST_HOLD:
			begin
				// only the vector table request may follow runtime
				next_r.alt_vec = r.boot_seg & r.boot_sync2[1]; // [RQ11]
			end
			default:
			begin
				next_r.state = cfd_pkg::CFD_ST_LOAD;
			end
		endcase
	end

	// =====================================================================
	// registers
	always_ff @(posedge CORE_CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			r <= '0;
			r.state <= cfd_pkg::CFD_ST_LOAD;
			r.dbg <= cfd_pkg::CFD_DBG_NONE;
			r.win <= `CFD_RST_WIN;
			r.lv1 <= `CFD_RST_LEVEL;
			r.lv2 <= `CFD_RST_LEVEL;
			r.lv3 <= `CFD_RST_LEVEL;
		end
		else
		begin
			r <= next_r;
		end
	end

	// =====================================================================
	// outputs straight from flops
	assign WIN_EIGHTHS_O = r.win;
	assign I2C1_PRIMARY_O = r.i2c1;
	assign I2C2_PRIMARY_O = r.i2c2;
	assign TEST_PORT_ON_O = r.test_on; // only set together with loaded
	assign DEBUG_PAIR_O = r.dbg;
	assign DEBUG_RESERVED_O = r.dbg_rsv;
	assign DAC_TIED_O = r.dac_tied;
	assign SET1_LEVEL_O = r.lv1;
	assign SET2_LEVEL_O = r.lv2;
	assign SET3_LEVEL_O = r.lv3;
	assign LEVEL_RESERVED_O = r.lv_rsv;
	assign ALT_VECTOR_ON_O = r.alt_vec;
	assign LOADED_O = r.loaded;

	// =====================================================================
	// checks
	property p_hold;
		@(posedge CORE_CLK_I) disable iff (!NRST_I)
		$past(r.loaded) |-> $stable(r.win) && $stable(r.lv1) && $stable(r.dbg);
	endproperty
	a_hold: assert property (p_hold) else $error("decoded fields changed after load"); // [RQ12]

	property p_load_time;
		@(posedge CORE_CLK_I) disable iff (!NRST_I)
		$rose(NRST_I) |-> !r.loaded [*4] ##1 r.loaded;
	endproperty
	a_load_time: assert property (p_load_time) else $error("load not done in four cycles"); // [RQ12]

	property p_altvec;
		@(posedge CORE_CLK_I) disable iff (!NRST_I)
		ALT_VECTOR_ON_O |-> r.boot_seg && $past(ALT_VECTOR_REQ_I, 3);
	endproperty
	a_altvec: assert property (p_altvec) else $error("alternate table without boot segment"); // [RQ11]

	property p_test;
		@(posedge CORE_CLK_I) disable iff (!NRST_I)
		$rose(r.loaded) |-> TEST_PORT_ON_O == $past(r.sync2[`CFD_TEST_BIT]);
	endproperty
	a_test: assert property (p_test) else $error("test port enable mismatch"); // [RQ4]

	property p_dac;
		@(posedge CORE_CLK_I) disable iff (!NRST_I)
		$rose(r.loaded) |-> DAC_TIED_O != $past(r.sync2[`CFD_DAC_BIT]);
	endproperty
	a_dac: assert property (p_dac) else $error("dac tie polarity wrong"); // [RQ7]

	property p_i2c;
		@(posedge CORE_CLK_I) disable iff (!NRST_I)
		$rose(r.loaded) |-> I2C1_PRIMARY_O == $past(r.sync2[`CFD_I2C1_BIT])
			&& I2C2_PRIMARY_O == $past(r.sync2[`CFD_I2C2_BIT]);
	endproperty
	a_i2c: assert property (p_i2c) else $error("i2c pin choice mismatch"); // [RQ2] [RQ3]

	property p_win;
		@(posedge CORE_CLK_I) disable iff (!NRST_I)
		$rose(r.loaded) && $past(r.sync2[`CFD_WIN_LSB +: 2]) == 2'h3 |-> WIN_EIGHTHS_O == 4'h2;
	endproperty
	a_win: assert property (p_win) else $error("window code 11 not 25 percent"); // [RQ1]

	property p_level;
		@(posedge CORE_CLK_I) disable iff (!NRST_I)
		$rose(r.loaded) && !LEVEL_RESERVED_O |->
			SET1_LEVEL_O == 3'($past(r.sync2[`CFD_SET1_LSB +: 3]) + 3'h1);
	endproperty
	a_level: assert property (p_level) else $error("set one level off"); // [RQ8]

	property p_dbg;
		@(posedge CORE_CLK_I) disable iff (!NRST_I)
		$rose(r.loaded) && $past(r.sync2[`CFD_DBG_LSB +: 2]) == 2'h3 |->
			DEBUG_PAIR_O == 4'h2;
	endproperty
	a_dbg: assert property (p_dbg) else $error("debug code 11 not pair one"); // [RQ5]

endmodule : cfd_config_decode

// ---- testbench/test_cfd_config_decode.sv ----
// Purpose: self-checking bench for the config field decoder
// Assumes: one load per reset, outputs valid at the 4th edge after release
// Notes: each row reloads the decoder through a fresh reset
`timescale 1ns/10ps
module test_cfd_config_decode;
	typedef struct packed
	{
		logic [16:0] word;
		logic [3:0] win;
		logic [3:0] dbg;
		logic [2:0] s1;
		logic [2:0] s2;
		logic [2:0] s3;
	} cfd_row_t;

	// =====================================================================
	// signals
	logic CORE_CLK_I;
	logic NRST_I;
	logic [16:0] CFG_WORD_I;
	logic BOOT_SEG_PRESENT_I;
	logic ALT_VECTOR_REQ_I;
	logic [3:0] WIN_EIGHTHS_O;
	logic I2C1_PRIMARY_O;
	logic I2C2_PRIMARY_O;
	logic TEST_PORT_ON_O;
	logic [3:0] DEBUG_PAIR_O;
	logic DEBUG_RESERVED_O;
	logic DAC_TIED_O;
	logic [2:0] SET1_LEVEL_O;
	logic [2:0] SET2_LEVEL_O;
	logic [2:0] SET3_LEVEL_O;
	logic LEVEL_RESERVED_O;
	logic ALT_VECTOR_ON_O;
	logic LOADED_O;
	int miscompares;
	int check_count;
	cfd_row_t rows [7];
	cfd_row_t r;

	cfd_config_decode dut
	(
		.CORE_CLK_I(CORE_CLK_I), .NRST_I(NRST_I), .CFG_WORD_I(CFG_WORD_I),
		.BOOT_SEG_PRESENT_I(BOOT_SEG_PRESENT_I), .ALT_VECTOR_REQ_I(ALT_VECTOR_REQ_I),
		.WIN_EIGHTHS_O(WIN_EIGHTHS_O), .I2C1_PRIMARY_O(I2C1_PRIMARY_O),
		.I2C2_PRIMARY_O(I2C2_PRIMARY_O), .TEST_PORT_ON_O(TEST_PORT_ON_O),
		.DEBUG_PAIR_O(DEBUG_PAIR_O), .DEBUG_RESERVED_O(DEBUG_RESERVED_O),
		.DAC_TIED_O(DAC_TIED_O), .SET1_LEVEL_O(SET1_LEVEL_O), .SET2_LEVEL_O(SET2_LEVEL_O),
		.SET3_LEVEL_O(SET3_LEVEL_O), .LEVEL_RESERVED_O(LEVEL_RESERVED_O),
		.ALT_VECTOR_ON_O(ALT_VECTOR_ON_O), .LOADED_O(LOADED_O)
	);

	// =====================================================================
	// clock, 5 ns period
	initial
	begin
		CORE_CLK_I = 1'b0;
		forever #2.5 CORE_CLK_I = ~CORE_CLK_I;
	end

	// compare seen against expected
	task check(input logic [3:0] seen, input logic [3:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// print counts and verdict
	task wrap_up();
		$display("miscompares %0d check_count %0d", miscompares, check_count);
		if (miscompares == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : wrap_up

	// values held while in reset
	task reset_vals();
		check(WIN_EIGHTHS_O, 4'h6);
		check({1'b0, SET1_LEVEL_O}, 4'h1);
		check(DEBUG_PAIR_O, 4'h1);
		check({3'h0, LOADED_O}, 4'h0);
		check({3'h0, TEST_PORT_ON_O}, 4'h0);
	endtask : reset_vals

	// reset, present word, wait for the load at the 4th edge
	task load(input logic [16:0] word, input logic boot);
		NRST_I = 1'b0;
		CFG_WORD_I = word;
		BOOT_SEG_PRESENT_I = boot;
		@(posedge CORE_CLK_I);
		#1 NRST_I = 1'b1;
		repeat (3) @(posedge CORE_CLK_I);
		#1 check({3'h0, LOADED_O}, 4'h0);
		@(posedge CORE_CLK_I);
		#1 check({3'h0, LOADED_O}, 4'h1);
	endtask : load

	// =====================================================================
	// watchdog
	initial
	begin
		#20000;
		miscompares++;
		wrap_up();
	end

	// =====================================================================
	// main sequence
	initial
	begin
		miscompares = 0;
		check_count = 0;
		NRST_I = 1'b0;
		CFG_WORD_I = 17'h00000;
		BOOT_SEG_PRESENT_I = 1'b0;
		ALT_VECTOR_REQ_I = 1'b0;
		// rows program legal debug codes only
		rows[0] = {17'h1f074, 4'h6, 4'h2, 3'h1, 3'h7, 3'h0};
		rows[1] = {17'h006c9, 4'h4, 4'h4, 3'h7, 3'h1, 3'h1};
		rows[2] = {17'h05f3e, 4'h3, 4'h8, 3'h0, 3'h4, 3'h2};
		rows[3] = {17'h1bdc3, 4'h2, 4'h4, 3'h6, 3'h0, 3'h7};
		rows[4] = {17'h02960, 4'h6, 4'h2, 3'h2, 3'h6, 3'h1};
		rows[5] = {17'h11460, 4'h6, 4'h2, 3'h5, 3'h3, 3'h5};
		rows[6] = {17'h02360, 4'h6, 4'h2, 3'h4, 3'h5, 3'h1};
		repeat (2) @(posedge CORE_CLK_I);
		#1 reset_vals();
		// table of ordinary decodes
		foreach (rows[i])
		begin
			r = rows[i];
			load(r.word, 1'b0);
			check(WIN_EIGHTHS_O, r.win);
			check({3'h0, I2C1_PRIMARY_O}, {3'h0, r.word[2]});
			check({3'h0, I2C2_PRIMARY_O}, {3'h0, r.word[3]});
			check({3'h0, TEST_PORT_ON_O}, {3'h0, r.word[4]});
			check(DEBUG_PAIR_O, r.dbg);
			check({3'h0, DEBUG_RESERVED_O}, {3'h0, r.dbg == 4'h1});
			check({3'h0, DAC_TIED_O}, {3'h0, ~r.word[7]});
			check({1'b0, SET1_LEVEL_O}, {1'b0, r.s1});
			check({1'b0, SET2_LEVEL_O}, {1'b0, r.s2});
			check({1'b0, SET3_LEVEL_O}, {1'b0, r.s3});
			check({3'h0, LEVEL_RESERVED_O}, {3'h0, r.s1 == 3'h0 || r.s2 == 3'h0 || r.s3 == 3'h0});
			check({3'h0, ALT_VECTOR_ON_O}, 4'h0);
		end
		// awkward: reserved debug code on purpose, nothing routed
		load(17'h0bd83, 1'b0);
		check(DEBUG_PAIR_O, 4'h1);
		check({3'h0, DEBUG_RESERVED_O}, 4'h1);
		// alternate table with boot segment, 3 edge latency
		load(17'h0f074, 1'b1);
		ALT_VECTOR_REQ_I = 1'b1;
		repeat (2) @(posedge CORE_CLK_I);
		#1 check({3'h0, ALT_VECTOR_ON_O}, 4'h0);
		@(posedge CORE_CLK_I);
		#1 check({3'h0, ALT_VECTOR_ON_O}, 4'h1);
		ALT_VECTOR_REQ_I = 1'b0;
		// later word changes ignored
		CFG_WORD_I = 17'h006c9;
		BOOT_SEG_PRESENT_I = 1'b0;
		repeat (6) @(posedge CORE_CLK_I);
		#1 check(WIN_EIGHTHS_O, 4'h6);
		check(DEBUG_PAIR_O, 4'h2);
		check({3'h0, ALT_VECTOR_ON_O}, 4'h0);
		// request without boot segment stays off
		ALT_VECTOR_REQ_I = 1'b1;
		load(17'h0f074, 1'b0);
		repeat (5) @(posedge CORE_CLK_I);
		#1 check({3'h0, ALT_VECTOR_ON_O}, 4'h0);
		// reset in mid-run
		NRST_I = 1'b0;
		#1 reset_vals();
		check({3'h0, ALT_VECTOR_ON_O}, 4'h0);
		wrap_up();
	end
endmodule : test_cfd_config_decode
